// *** logic/sts_scan_trigger_sequencer.sv ***
`default_nettype none

module sts_scan_trigger_sequencer
  import sts_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = STS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Trigger pin and host command bytes
  input  wire logic        ext_trigger,
  input  wire sts_cmd_t    host_cmd,
  // Capture and decode engine
  input  wire sts_eng_t    engine,
  output logic             image_req,
  output logic             scan_active,
  output logic      [3:0]  buf_depth
);

  // ==========================================================================
  // Trigger pin and millisecond timebase
  logic ext_level;
  logic ext_rise;
  logic ms_tick;
  logic tick_restart;

  sts_trig_sync u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pin_in  (ext_trigger),
    .level   (ext_level),
    .rise    (ext_rise)
  );

  sts_ms_tick #(
    .TICKS (TICK_CYCLES)
  ) u_tick (
    .clock   (clock),
    .sys_rst (sys_rst),
    .restart (tick_restart),
    .tick    (ms_tick)
  );

  // ==========================================================================
  // Register bus
  sts_cfg_t    cfg;
  sts_cfg_t    next_cfg;
  logic [7:0]  addr_q;
  logic [7:0]  next_addr_q;
  logic        wr_pend;
  logic        next_wr_pend;
  logic [31:0] next_hrdata;
  logic        sw_act;
  logic        next_sw_act;
  logic        sw_deact;
  logic        next_sw_deact;
  sts_state_t  state;
  logic [7:0]  img_count;
  logic        addr_phase;

  // A read is answered from the next register values so that a read right
  // behind a write to the same register already sees the new value.
  assign addr_phase = hsel & htrans[1] & hready;

  always_comb begin
    next_cfg      = cfg;
    next_addr_q   = addr_q;
    next_wr_pend  = 1'b0;
    next_sw_act   = 1'b0;
    next_sw_deact = 1'b0;
    next_hrdata   = hrdata;
    if (wr_pend) begin
      case (addr_q)
        STS_ADDR_CTRL: begin
          next_cfg.op_mode   = sts_op_mode_t'(hwdata[STS_CTRL_OP_LSB +: 2]);
          next_cfg.work_mode = sts_work_mode_t'(hwdata[STS_CTRL_WORK_LSB +: 2]);
        end
        STS_ADDR_INTERVAL: next_cfg.interval_ms = hwdata[15:0];
        STS_ADDR_DELAY: begin
          next_cfg.delay_ms = (hwdata[31:0] > {18'h0_0000, STS_DELAY_MAX}) ? STS_DELAY_MAX
                                                                              : hwdata[13:0];
        end
        STS_ADDR_REPEAT: next_cfg.repeat_count = hwdata[7:0];
        STS_ADDR_BUFDEPTH: begin
          if (hwdata[31:0] < {28'h000_0000, STS_BUF_MIN}) begin
            next_cfg.buf_depth = STS_BUF_MIN;
          end else if (hwdata[31:0] > {28'h000_0000, STS_BUF_MAX}) begin
            next_cfg.buf_depth = STS_BUF_MAX;
          end else begin
            next_cfg.buf_depth = hwdata[3:0];
          end
        end
        STS_ADDR_NETPORT: next_cfg.net_port = hwdata[15:0];
        STS_ADDR_COMMAND: begin
          next_sw_act   = hwdata[STS_CMD_ACT_BIT];
          next_sw_deact = hwdata[STS_CMD_DEACT_BIT];
        end
        default: next_cfg = cfg;
      endcase
    end
    if (addr_phase) begin
      next_addr_q  = haddr[7:0];
      next_wr_pend = hwrite & (haddr[31:8] == 24'h00_0000);
      if (!hwrite) begin
        next_hrdata = 32'h0000_0000;
        if (haddr[31:8] == 24'h00_0000) begin
          case (haddr[7:0])
            STS_ADDR_CTRL:     next_hrdata = {28'h000_0000, next_cfg.work_mode, next_cfg.op_mode};
            STS_ADDR_INTERVAL: next_hrdata = {16'h0000, next_cfg.interval_ms};
            STS_ADDR_DELAY:    next_hrdata = {18'h0_0000, next_cfg.delay_ms};
            STS_ADDR_REPEAT:   next_hrdata = {24'h00_0000, next_cfg.repeat_count};
            STS_ADDR_BUFDEPTH: next_hrdata = {28'h000_0000, next_cfg.buf_depth};
            STS_ADDR_NETPORT:  next_hrdata = {16'h0000, next_cfg.net_port};
            STS_ADDR_STATUS:   next_hrdata = {16'h0000, img_count, 3'h0, ext_level, scan_active, 1'b0, state};
            default:           next_hrdata = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg.op_mode      <= OP_STREAM;
      cfg.work_mode    <= WM_LATCH;
      cfg.interval_ms  <= STS_INTERVAL_RST;
      cfg.delay_ms     <= STS_DELAY_RST;
      cfg.repeat_count <= STS_REPEAT_RST;
      cfg.buf_depth    <= STS_BUF_RST;
      cfg.net_port     <= STS_NETPORT_RST;
      addr_q           <= 8'h00;
      wr_pend          <= 1'b0;
      hrdata           <= 32'h0000_0000;
      hreadyout        <= 1'b1;
      hresp            <= 1'b0;
      sw_act           <= 1'b0;
      sw_deact         <= 1'b0;
    end else begin
      cfg       <= next_cfg;
      addr_q    <= next_addr_q;
      wr_pend   <= next_wr_pend;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      sw_act    <= next_sw_act;
      sw_deact  <= next_sw_deact;
    end
  end

  assign buf_depth = cfg.buf_depth;

  // ==========================================================================
  // Host byte sequence matcher
  sts_match_t match;
  sts_match_t next_match;
  logic       byte_ok;
  logic       seq_act;
  logic       seq_deact;
  logic       host_act;
  logic       host_deact;

  // Network bytes from any other port are dropped before the matcher.
  assign byte_ok   = host_cmd.valid & (~host_cmd.from_net | (host_cmd.port == cfg.net_port));
  assign seq_act   = byte_ok & (match == MT_ACT) & (host_cmd.data == STS_BYTE_CR);
  assign seq_deact = byte_ok & (match == MT_DACT) & (host_cmd.data == STS_BYTE_CR);
  assign host_act   = seq_act | sw_act;
  assign host_deact = seq_deact | sw_deact;

  always_comb begin
    next_match = match;
    if (byte_ok) begin
      next_match = (host_cmd.data == STS_BYTE_SYN) ? MT_SYN : MT_WAIT;
      if (match == MT_SYN && host_cmd.data == STS_BYTE_ACT) begin
        next_match = MT_ACT;
      end else if (match == MT_SYN && host_cmd.data == STS_BYTE_DEACT) begin
        next_match = MT_DACT;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      match <= MT_WAIT;
    end else begin
      match <= next_match;
    end
  end

  // ==========================================================================
  // Trigger sequencer
  sts_state_t   next_state;
  sts_op_mode_t op_prev;
  logic [15:0]  ms_count;
  logic [15:0]  next_ms_count;
  logic [7:0]   next_img_count;
  logic         next_image_req;
  logic         next_scan_active;
  logic         host_src;
  logic         next_host_src;
  logic         cont_mode;
  logic         mode_chg;
  logic         ext_go;
  logic         stop_read;
  logic         start_now;
  logic         start_delay;
  logic [15:0]  ms_inc;

  assign cont_mode = (cfg.op_mode == OP_STREAM) | (cfg.op_mode == OP_PRES);
  assign mode_chg  = (cfg.op_mode != op_prev);
  assign ext_go    = (cfg.op_mode == OP_EXT) & (ext_rise | host_act);
  assign ms_inc    = ms_count + 16'h0001;
  // A released trigger only aborts a read that the pin itself started.
  assign stop_read = engine.decode_ok | engine.read_timeout | host_deact | mode_chg
                   | ((cfg.op_mode == OP_EXT) & (cfg.work_mode == WM_LEVEL) & ~host_src & ~ext_level);

  always_comb begin
    next_state       = state;
    next_ms_count    = ms_count;
    next_img_count   = img_count;
    next_image_req   = 1'b0;
    next_scan_active = scan_active;
    next_host_src    = host_src;
    tick_restart     = 1'b0;
    start_now        = 1'b0;
    start_delay      = 1'b0;
    case (state)
      ST_IDLE: begin
        next_scan_active = 1'b0;
        if (cfg.op_mode == OP_SELF && ms_tick) begin
          next_ms_count = ms_inc;
          if (ms_inc >= cfg.interval_ms) begin
            start_now = 1'b1;
          end
        end else if (ext_go) begin
          next_host_src = host_act & ~ext_rise;
          start_now     = (cfg.delay_ms == 14'h0000);
          start_delay   = (cfg.delay_ms != 14'h0000);
        end
      end
      ST_DELAY: begin
        if (stop_read) begin
          next_state = ST_IDLE;
        end else if (ms_tick) begin
          next_ms_count = ms_inc;
          if (ms_inc >= {2'b00, cfg.delay_ms}) begin
            start_now = 1'b1;
          end
        end
      end
      ST_ACTIVE: begin
        if (stop_read) begin
          next_state       = ST_IDLE;
          next_scan_active = 1'b0;
          next_ms_count    = 16'h0000;
          tick_restart     = 1'b1;
        end else if (engine.image_done) begin
          if (cfg.op_mode == OP_EXT && cfg.work_mode == WM_SINGLE) begin
            next_state       = ST_IDLE;
            next_scan_active = 1'b0;
          end else if (cfg.op_mode == OP_EXT && cfg.work_mode == WM_HOLD) begin
            if (img_count < cfg.repeat_count) begin
              next_image_req = 1'b1;
              next_img_count = img_count + 8'h01;
            end else begin
              next_state       = ST_IDLE;
              next_scan_active = 1'b0;
            end
          end else begin
            next_image_req = 1'b1;
          end
        end
      end
      ST_STREAM: begin
        next_scan_active = 1'b1;
        next_image_req   = engine.image_done;
      end
      default: next_state = ST_IDLE;
    endcase
    if (start_delay) begin
      next_state    = ST_DELAY;
      next_ms_count = 16'h0000;
      tick_restart  = 1'b1;
    end
    if (start_now) begin
      next_state       = ST_ACTIVE;
      next_image_req   = 1'b1;
      next_scan_active = 1'b1;
      next_img_count   = 8'h01;
      next_ms_count    = 16'h0000;
    end
    if (cont_mode) begin
      next_state       = ST_STREAM;
      next_scan_active = 1'b1;
      next_image_req   = (state != ST_STREAM) | engine.image_done;
    end else if (state == ST_STREAM) begin
      next_state       = ST_IDLE;
      next_scan_active = 1'b0;
      next_image_req   = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state       <= ST_STREAM;
      op_prev     <= OP_STREAM;
      ms_count    <= 16'h0000;
      img_count   <= 8'h00;
      image_req   <= 1'b0;
      scan_active <= 1'b0;
      host_src    <= 1'b0;
    end else begin
      state       <= next_state;
      op_prev     <= cfg.op_mode;
      ms_count    <= next_ms_count;
      img_count   <= next_img_count;
      image_req   <= next_image_req;
      scan_active <= next_scan_active;
      host_src    <= next_host_src;
    end
  end

  // ==========================================================================
  // Checks
  a_reset_stream_mode: assert property (@(posedge clock) sys_rst |=> cfg.op_mode == OP_STREAM)
    else $error("Streaming mode not selected after reset.");

  a_stream_mode_entry: assert property (@(posedge clock) disable iff (sys_rst)
    (!sys_rst && cfg.op_mode == OP_STREAM) |=> (state == ST_STREAM) && scan_active)
    else $error("Streaming mode did not take effect at once.");

  a_ext_start_now: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_IDLE && cfg.op_mode == OP_EXT && !mode_chg && ext_rise && cfg.delay_ms == 14'h0000)
    |=> (state == ST_ACTIVE) && image_req && scan_active)
    else $error("External trigger with zero delay did not start a read.");

  a_host_trigger_start: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_IDLE && cfg.op_mode == OP_EXT && !mode_chg && host_act && cfg.delay_ms != 14'h0000)
    |=> (state == ST_DELAY) && !scan_active)
    else $error("Host trigger did not start the delay.");

  a_single_one_image: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_ACTIVE && cfg.op_mode == OP_EXT && cfg.work_mode == WM_SINGLE && !mode_chg && engine.image_done)
    |=> (state == ST_IDLE) && !image_req && !scan_active)
    else $error("Single capture took more than one image.");

  a_level_release_abort: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_ACTIVE && cfg.op_mode == OP_EXT && cfg.work_mode == WM_LEVEL && !host_src && !ext_level)
    |=> (state == ST_IDLE) && !scan_active)
    else $error("Released level trigger did not abort the read.");

  a_latched_holds_on: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_ACTIVE && cfg.op_mode == OP_EXT && cfg.work_mode == WM_LATCH && !stop_read)
    |=> (state == ST_ACTIVE) && scan_active)
    else $error("Latched read ended without decode or timeout.");

  a_hold_repeat_count: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_ACTIVE && cfg.op_mode == OP_EXT && cfg.work_mode == WM_HOLD && !stop_read
     && engine.image_done && img_count < cfg.repeat_count)
    |=> image_req && (img_count == $past(img_count) + 8'h01))
    else $error("Hold mode did not repeat the reading cycle.");

  a_deact_stops_scan: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_ACTIVE && host_deact && !cont_mode) |=> !scan_active ##1 !scan_active)
    else $error("Deactivate did not stop scanning.");

  a_buf_depth_range: assert property (@(posedge clock) disable iff (sys_rst)
    cfg.buf_depth >= STS_BUF_MIN && cfg.buf_depth <= STS_BUF_MAX)
    else $error("Image buffer depth out of range.");

endmodule

`default_nettype wire

// *** logic/sts_pkg.sv ***
// Summary of operation
// - Four modes: self-timed, external, presentation, streaming; streaming after reset; changes apply immediately.
// - Self-timed mode starts a read at every interval expiry, endlessly while selected.
// - External mode starts on trigger pulse or level, immediately unless delay configured.
// - Host trigger command in external mode acts like the external trigger input.
// - Single-capture mode takes one image per trigger, decodes it, returns idle.
// - Hold-until-done mode searches regardless of trigger removal until decode or timeout.
// - Level-following mode aborts on trigger release; also ends on decode or timeout.
// - Latched mode, the default, stays triggered until decode or timeout.
// - Hold-until-done mode repeats image cycles up to repeat count, default 2.
// - Trigger delay 0 to 10000 ms, default 500; zero means no delay.
// - Image buffer depth held in range 1 to 10, default 1.
// - Byte sequences 16 54 0D activate and 16 55 0D deactivate scanning.
// - Remote activation scans until decode, deactivate sequence, or read timeout.
// - Network commands are accepted only on the TCP port, default 55256.
`default_nettype none

package sts_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned STS_CLK_PERIOD_NS = 20;
  localparam int unsigned STS_MS_NS         = 1_000_000;
  localparam int unsigned STS_TICK_CYCLES   = STS_MS_NS / STS_CLK_PERIOD_NS;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] STS_ADDR_CTRL     = 8'h00;
  localparam logic [7:0] STS_ADDR_INTERVAL = 8'h04;
  localparam logic [7:0] STS_ADDR_DELAY    = 8'h08;
  localparam logic [7:0] STS_ADDR_REPEAT   = 8'h0C;
  localparam logic [7:0] STS_ADDR_BUFDEPTH = 8'h10;
  localparam logic [7:0] STS_ADDR_NETPORT  = 8'h14;
  localparam logic [7:0] STS_ADDR_STATUS   = 8'h18;
  localparam logic [7:0] STS_ADDR_COMMAND  = 8'h1C;

  // Field positions.
  localparam int unsigned STS_CTRL_OP_LSB   = 0;
  localparam int unsigned STS_CTRL_WORK_LSB = 2;
  localparam int unsigned STS_CMD_ACT_BIT   = 0;
  localparam int unsigned STS_CMD_DEACT_BIT = 1;

  // ==========================================================================
  // Reset values and limits
  localparam logic [15:0] STS_INTERVAL_RST = 16'h03E8;
  localparam logic [13:0] STS_DELAY_RST    = 14'h01F4;
  localparam logic [13:0] STS_DELAY_MAX    = 14'h2710;
  localparam logic [7:0]  STS_REPEAT_RST   = 8'h02;
  localparam logic [3:0]  STS_BUF_RST      = 4'h1;
  localparam logic [3:0]  STS_BUF_MIN      = 4'h1;
  localparam logic [3:0]  STS_BUF_MAX      = 4'hA;
  localparam logic [15:0] STS_NETPORT_RST  = 16'hD7D8;

  // ==========================================================================
  // Host command bytes
  localparam logic [7:0] STS_BYTE_SYN   = 8'h16;
  localparam logic [7:0] STS_BYTE_ACT   = 8'h54;
  localparam logic [7:0] STS_BYTE_DEACT = 8'h55;
  localparam logic [7:0] STS_BYTE_CR    = 8'h0D;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    OP_SELF   = 2'b00,
    OP_EXT    = 2'b01,
    OP_PRES   = 2'b10,
    OP_STREAM = 2'b11
  } sts_op_mode_t;

  typedef enum logic [1:0] {
    WM_SINGLE = 2'b00,
    WM_HOLD   = 2'b01,
    WM_LEVEL  = 2'b10,
    WM_LATCH  = 2'b11
  } sts_work_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DELAY  = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_STREAM = 2'b11
  } sts_state_t;

  typedef enum logic [1:0] {
    MT_WAIT = 2'b00,
    MT_SYN  = 2'b01,
    MT_ACT  = 2'b10,
    MT_DACT = 2'b11
  } sts_match_t;

  typedef struct packed {
    logic decode_ok;
    logic read_timeout;
    logic image_done;
  } sts_eng_t;

  typedef struct packed {
    logic        valid;
    logic        from_net;
    logic [15:0] port;
    logic [7:0]  data;
  } sts_cmd_t;

  typedef struct packed {
    sts_op_mode_t   op_mode;
    sts_work_mode_t work_mode;
    logic [15:0]    interval_ms;
    logic [13:0]    delay_ms;
    logic [7:0]     repeat_count;
    logic [3:0]     buf_depth;
    logic [15:0]    net_port;
  } sts_cfg_t;

endpackage

`default_nettype wire

// *** logic/sts_trig_sync.sv ***
`default_nettype none

module sts_trig_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Pin and its clean views
  input  wire logic pin_in,
  output logic      level,
  output logic      rise
);

  logic meta;
  logic sync;
  logic prev;

  // ==========================================================================
  // Two-stage synchroniser; only the second stage feeds the edge detector.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin_in;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level = sync;
  assign rise  = sync & ~prev;

endmodule

`default_nettype wire

// *** logic/sts_ms_tick.sv ***
`default_nettype none

module sts_ms_tick #(
  parameter int unsigned TICKS = 50000
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Control and enable pulse
  input  wire logic restart,
  output logic      tick
);

  localparam int unsigned CW = (TICKS > 1) ? $clog2(TICKS) : 1;

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_tick;

  // ==========================================================================
  // Restart realigns the phase so a delay is never short by a partial period.
  always_comb begin
    next_tick  = 1'b0;
    next_count = count + CW'(1);
    if (restart) begin
      next_count = '0;
    end else if (count == CW'(TICKS - 1)) begin
      next_count = '0;
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule

`default_nettype wire

// *** tb/sts_host_model.sv ***
`default_nettype none
module sts_host_model
  import sts_pkg::*;
(
  // Clock
  input  wire logic clock,
  // Trigger pin and command bytes
  output logic      ext_trigger,
  output sts_cmd_t  host_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ext_trigger = 1'b0;
    host_cmd = '0;
  end
  // ==========================================================================
  // Trigger source: a pulse is a short level, so one task serves both.
  task automatic pin(input logic v);
    @(posedge clock);
    ext_trigger <= v;
  endtask
  // ==========================================================================
  // Host: only the fixed sequences are sent, and they always differ.
  task automatic send(input logic [7:0] key, input logic net, input logic [15:0] port);
    logic [7:0] seq [3];
    seq = '{STS_BYTE_SYN, key, STS_BYTE_CR};
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      host_cmd <= '{1'b1, net, port, seq[i]};
    end
    @(posedge clock);
    // Released bytes are scrambled so nothing can lean on a stale value.
    host_cmd <= '{1'b0, net, ~port, ~seq[2]};
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none
module tb
  import sts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize;
  logic        hreadyout;
  logic        hresp;
  logic        ext_trigger;
  logic        image_req;
  logic        scan_active;
  logic [3:0]  buf_depth;
  sts_cmd_t    host_cmd;
  sts_eng_t    engine = '0;
  int          failures = 0;
  int          tests_run = 0;
  int          reqs = 0;

  always #10 clock = ~clock;
  always @(posedge clock) if (image_req === 1'b1) reqs <= reqs + 1;

  sts_scan_trigger_sequencer #(.TICK_CYCLES(TK)) dut_u (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_trigger(ext_trigger), .host_cmd(host_cmd),
    .engine(engine), .image_req(image_req), .scan_active(scan_active), .buf_depth(buf_depth));
  sts_host_model host_u (.clock(clock), .ext_trigger(ext_trigger), .host_cmd(host_cmd));

  // ==========================================================================
  // Access tasks.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    hsize <= 3'b010;
    htrans <= 2'b10;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(a, 1'b0, '0, r);
    chk(nm, exp, r);
    chk("hresp", 0, {31'h0000_0000, hresp});
  endtask
  task automatic wait_req(output int n);
    n = 0;
    while (image_req !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic eng(input logic [2:0] v);
    @(posedge clock);
    engine <= v;
    @(posedge clock);
    engine <= '0;
  endtask
  task automatic trig();
    host_u.pin(1'b1);
    host_u.pin(1'b0);
  endtask
  task automatic close_out();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // Sequence.
  initial begin
    int n;
    int r;
    logic [7:0]  ra [7];
    logic [31:0] rv [7];
    ra = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h40};
    rv = '{32'h0000_000F, 32'h0000_03E8, 32'h0000_01F4, 32'h0000_0002, 32'h0000_0001, 32'h0000_D7D8, '0};
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    cyc(2);
    chk("stream", 1, scan_active);
    chk("depth", 1, buf_depth);
    for (int i = 0; i < 7; i++) rd("reg", ra[i], rv[i]);
    wr(STS_ADDR_BUFDEPTH, '0);
    rd("depth_lo", STS_ADDR_BUFDEPTH, 1);
    wr(STS_ADDR_BUFDEPTH, 32'h0000_000B);
    rd("depth_hi", STS_ADDR_BUFDEPTH, 32'h0000_000A);
    wr(STS_ADDR_DELAY, 32'h0000_3000);
    rd("delay_max", STS_ADDR_DELAY, 32'h0000_2710);
    wr(STS_ADDR_DELAY, '0);
    wr(STS_ADDR_CTRL, 32'h0000_000D);
    cyc(2);
    chk("ext_idle", 0, scan_active);
    trig();
    wait_req(n);
    chk("ext_req", 1, image_req);
    cyc(5);
    chk("latched", 1, scan_active);
    eng(3'b100);
    cyc(2);
    chk("latch_end", 0, scan_active);
    wr(STS_ADDR_CTRL, 32'h0000_0009);
    host_u.pin(1'b1);
    wait_req(n);
    cyc(3);
    chk("level_on", 1, scan_active);
    host_u.pin(1'b0);
    cyc(4);
    chk("level_off", 0, scan_active);
    host_u.pin(1'b1);
    wait_req(n);
    eng(3'b010);
    cyc(2);
    chk("level_tmo", 0, scan_active);
    host_u.pin(1'b0);
    wr(STS_ADDR_CTRL, 32'h0000_0001);
    trig();
    wait_req(n);
    eng(3'b001);
    cyc(2);
    chk("single", 0, scan_active);
    wr(STS_ADDR_CTRL, 32'h0000_0005);
    r = reqs;
    trig();
    wait_req(n);
    eng(3'b001);
    cyc(3);
    chk("hold", 1, scan_active);
    eng(3'b001);
    cyc(2);
    chk("hold_end", 0, scan_active);
    chk("images", 2, reqs - r);
    wr(STS_ADDR_CTRL, 32'h0000_000D);
    host_u.send(STS_BYTE_ACT, 1'b1, 16'h1234);
    cyc(2);
    chk("bad_port", 0, scan_active);
    host_u.send(STS_BYTE_ACT, 1'b0, '0);
    cyc(1);
    chk("activate", 1, scan_active);
    host_u.send(STS_BYTE_DEACT, 1'b1, STS_NETPORT_RST);
    cyc(1);
    chk("deactivate", 0, scan_active);
    wr(STS_ADDR_COMMAND, 32'h0000_0001);
    cyc(1);
    chk("cmd_act", 1, scan_active);
    rd("status", STS_ADDR_STATUS, 32'h0000_010A);
    wr(STS_ADDR_COMMAND, 32'h0000_0002);
    cyc(1);
    chk("cmd_deact", 0, scan_active);
    wr(STS_ADDR_DELAY, 32'h0000_0002);
    host_u.send(STS_BYTE_ACT, 1'b1, STS_NETPORT_RST);
    wait_req(n);
    chk("delayed", 1, n >= 2 * TK && n <= 2 * TK + 5);
    eng(3'b100);
    wr(STS_ADDR_INTERVAL, 32'h0000_0001);
    wr(STS_ADDR_CTRL, '0);
    wait_req(n);
    chk("self_1", 1, image_req);
    eng(3'b100);
    wait_req(n);
    chk("self_2", 1, image_req);
    wr(STS_ADDR_CTRL, 32'h0000_000E);
    cyc(2);
    chk("presentation", 1, scan_active);
    wr(STS_ADDR_CTRL, 32'h0000_000F);
    cyc(2);
    chk("stream_again", 1, scan_active);
    close_out();
  end

  // The whole sequence needs a few hundred cycles; this bound is generous.
  initial begin
    #100000;
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
